// ---- design/fic_regs.svh ----
`ifndef FIC_REGS_SVH
`define FIC_REGS_SVH

// Command words
`define FIC_CMD_IDLE      16'h0000
`define FIC_CMD_STB_CLR   16'h5140
`define FIC_CMD_STB_EN    16'h5141
`define FIC_CMD_STB_DIS   16'h5142
`define FIC_CMD_STB_RD    16'h5143
`define FIC_CMD_RD_FC     16'h5144
`define FIC_CMD_AUX_RATE  16'h5145
`define FIC_CMD_ROM_TEST  16'h3000
`define FIC_CMD_SRAM_TEST 16'h3001
`define FIC_CMD_WIDE16    16'h0801
`define FIC_CMD_WIDE8     16'h0821
`define FIC_CMD_ID        16'h3400
`define FIC_CMD_REV       16'h3800
`define FIC_TONE_OP       4'h6
`define FIC_SELFTEST_OP   4'h3
`define FIC_STS_REFUSED   16'hffff

// Field positions
`define FIC_STB_BIT       5
`define FIC_TRF_BIT       10
`define FIC_CRF_BIT       9
`define FIC_EMF_BIT       11
`define FIC_ATT_MSB       8
`define FIC_ATT_LSB       5
`define FIC_SLOT_MSB      4
`define FIC_LEVEL_MAX     5'h0f
`define FIC_TABLE_LEVEL   4'h1
`define FIC_ROUTE_DEFAULT 2'h0

// Timing
`define FIC_CLK_MHZ       100
`define FIC_FRAME_US      30000
`define FIC_SAMPLES       240
`define FIC_SAMPLE_CYC    ((`FIC_FRAME_US * `FIC_CLK_MHZ) / `FIC_SAMPLES)
`define FIC_WIDTH_WAIT_MS 10
`define FIC_WIDTH_WAIT_CYC (`FIC_WIDTH_WAIT_MS * 1000 * `FIC_CLK_MHZ)

// Host-side register word indices (byte address bits 4:2)
`define FIC_REG_CMD       3'h0
`define FIC_REG_STATUS    3'h1
`define FIC_REG_CTRL      3'h2
`define FIC_REG_FLAGS     3'h3
`define FIC_REG_AUX       3'h4

`endif

// ---- design/fic_pkg.sv ----
package fic_pkg;
    typedef logic [15:0] fic_word_type;
    typedef enum logic [1:0] {ST_IDLE, ST_RATE_WAIT, ST_TONE} fic_state_type;
endpackage

// ---- design/fic_if.sv ----
`timescale 1ns/1ps
interface fic_if;
    logic [15:0] cmd_word;          // Command word from host
    logic        cmd_wr;            // One-cycle command strobe
    logic [15:0] status_word;       // Reply word
    logic        status_rdy;        // Status Ready level
    logic        status_rd;         // One-cycle read of status
    logic [15:0] aux_word;          // Auxiliary status word
    logic        aux_rdy;           // Aux status ready level
    logic        aux_rd;            // One-cycle read of aux word
    logic [2:0]  irq_sel;           // Interrupt source select
    logic        host_interrupt_n;  // Active-low interrupt

    modport device (input cmd_word, cmd_wr, status_rd, aux_rd, irq_sel,
                    output status_word, status_rdy, aux_word, aux_rdy, host_interrupt_n);
    modport host   (output cmd_word, cmd_wr, status_rd, aux_rd, irq_sel,
                    input status_word, status_rdy, aux_word, aux_rdy, host_interrupt_n);
endinterface

// ---- design/fic_frame_timer.sv ----
`timescale 1ns/1ps
`include "fic_regs.svh"
module fic_frame_timer
    import fic_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = `FIC_SAMPLE_CYC
)
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      sample_tick_o,
    output logic      frame_tick_o
);
    logic [23:0] div_q;
    logic [7:0]  samp_q;

    // Sample-rate enable; frame ends after the last sample of the block
    always_comb
    begin
        sample_tick_o = (div_q == 24'(SAMPLE_CYCLES - 1));
        frame_tick_o  = sample_tick_o && (samp_q == 8'(`FIC_SAMPLES - 1));
    end

    // Divider from the system clock
    always_ff @(posedge clk_i)
    begin
        if (rst_i || sample_tick_o)
            div_q <= 24'h000000;
        else
            div_q <= div_q + 24'h000001;
    end

    // Samples within one frame
    always_ff @(posedge clk_i)
    begin
        if (rst_i || frame_tick_o)
            samp_q <= 8'h00;
        else if (sample_tick_o)
            samp_q <= samp_q + 8'h01;
    end
endmodule // fic_frame_timer

// ---- design/fic_device.sv ----
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "fic_regs.svh"
// Summary of operation
// - Strobe pin goes low each active frame and stays low until cleared
// - Enable/disable strobe commands echo; enabled at reset
// - Clear deasserts strobe, reports prior level bit5
// - Read returns strobe, gpio levels, data flag
// - Strobe shares gpio 5, else plain gpio
// - Interrupt follows buffer-ok flags when selected
// - Rate N sets aux frame-count updates
// - Aux write raises ready; host read clears
// - Read frame count returns counter in idle state
// - Counter counts active frames, clears on entry
// - ROM test reports two fail bits
// - Memory test reports fail, overwrites memory
// - Width commands: no reply, internal reset
// - Host waits 10 ms, idles, reconfigures
// - Identification returns part code word
// - Revision returns four-digit version word
// - Tone accepted only in idle mode
// - Level is table plus offset, capped 15
// - Default routing sends tone to codec 1
// - Tone frames of 240 samples, status at end
// - Repeat keeps tone; idle command ends it
// - Slot zero gives timed silence
module fic_device
    import fic_pkg::*;
#(
    parameter int unsigned  SAMPLE_CYCLES = `FIC_SAMPLE_CYC,
    parameter logic [15:0]  DEVICE_CODE   = 16'h1a2b,  // Arbitrary value
    parameter logic [15:0]  REV_CODE      = 16'h0101   // Arbitrary value
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    fic_if.device            link,
    input  wire logic        speech_active_i,
    input  wire logic        send_buffer_ok_i,
    input  wire logic        receive_buffer_ok_i,
    input  wire logic        data_flag_i,
    input  wire logic [1:0]  codec_route_i,
    input  wire logic        table_rom_check_fail_i,
    input  wire logic        code_rom_check_fail_i,
    input  wire logic        ext_memory_check_fail_i,
    input  wire logic [7:0]  gpio_pin_i,
    input  wire logic [7:0]  gpio_out_i,
    input  wire logic [7:0]  gpio_oe_n_i,
    output logic [7:0]       gpio_pin_o,
    output logic [7:0]       gpio_oe_n_o,
    output logic [7:0]       gpio_level_o,
    output logic             mem_wide_o,
    output logic             sram_test_o,
    output logic             tone_on_o,
    output logic [4:0]       tone_slot_o,
    output logic [3:0]       tone_level_o,
    output logic [1:0]       tone_codec_o,
    output logic             sample_tick_o
);
    fic_state_type state_q;
    fic_word_type  status_q, aux_q, fc_q, rate_q, nth_q, pend_q, rsp_word;
    logic          status_rdy_q, aux_rdy_q, irq_n_q, strb_en_q, strobe_q;
    logic          pend_vld_q, act_q, srst_q, mem_wide_q, sram_test_q;
    logic          rst_all, frame_tick, rsp_valid, go_tone, go_rate, go_idle;
    logic          do_clr, do_en, do_dis, do_srst, do_sram, do_wide, tone_upd;
    logic [3:0]    att_q;
    logic [4:0]    slot_q, level_sum;
    logic [7:0]    s1_q, s2_q, s3_q, lvl_q;
    fic_word_type  tw;

    // Width commands reset all but the width, interrupt, test pulse and pin levels
    assign rst_all = rst_i || srst_q;

    fic_frame_timer #(
        .SAMPLE_CYCLES (SAMPLE_CYCLES)
    ) u_timer (
        .clk_i         (clk_i),
        .rst_i         (rst_all),
        .sample_tick_o (sample_tick_o),
        .frame_tick_o  (frame_tick)
    );

    // Pin synchronisers; a level counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_sync
            always_ff @(posedge clk_i)
            begin
                s1_q[g] <= gpio_pin_i[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (rst_i)
                    lvl_q[g] <= 1'b1;
                else if (s2_q[g] == s3_q[g])
                    lvl_q[g] <= s3_q[g];
            end
        end
    endgenerate

    // Tone word in hand: a fresh one in idle, or the pending one at frame end
    assign tw = (state_q == ST_TONE) ? pend_q : link.cmd_word;

    // Command decode and reply selection
    always_comb
    begin
        rsp_valid = 1'b0;
        rsp_word  = link.cmd_word;
        go_tone   = 1'b0;
        go_rate   = 1'b0;
        go_idle   = 1'b0;
        tone_upd  = 1'b0;
        do_clr    = 1'b0;
        do_en     = 1'b0;
        do_dis    = 1'b0;
        do_sram   = 1'b0;
        do_wide   = 1'b0;
        do_srst   = 1'b0;
        case (state_q)
            ST_RATE_WAIT:
            begin
                rsp_valid = link.cmd_wr;  // Second word echoed
                go_idle   = link.cmd_wr;
            end
            ST_TONE:
            begin
                // Host words only take effect at a frame boundary
                if (frame_tick && pend_vld_q)
                begin
                    rsp_valid = 1'b1;
                    rsp_word  = pend_q;
                    if (pend_q[15:12] == `FIC_TONE_OP && pend_q[11:9] == 3'h0)
                        tone_upd = 1'b1;
                    else if (pend_q == `FIC_CMD_IDLE)
                        go_idle = 1'b1;
                    else
                        rsp_word = `FIC_STS_REFUSED;
                end
            end
            default:
            begin
                rsp_valid = link.cmd_wr;
                case (link.cmd_word)
                    `FIC_CMD_STB_EN:  do_en = 1'b1;
                    `FIC_CMD_STB_DIS: do_dis = 1'b1;
                    `FIC_CMD_STB_CLR:
                    begin
                        do_clr   = 1'b1;
                        rsp_word = {10'h000, ~strobe_q, 5'h00};
                    end
                    `FIC_CMD_STB_RD:
                        rsp_word = {8'h00, lvl_q[7:6], ~strobe_q, 1'b0,
                                    lvl_q[3:1], data_flag_i};
                    `FIC_CMD_RD_FC:  rsp_word = fc_q;
                    `FIC_CMD_AUX_RATE: go_rate = 1'b1;
                    `FIC_CMD_ROM_TEST:
                        rsp_word = {`FIC_SELFTEST_OP, 1'b0, table_rom_check_fail_i,
                                    code_rom_check_fail_i, 9'h000};
                    `FIC_CMD_SRAM_TEST:
                    begin
                        do_sram  = 1'b1;
                        rsp_word = {`FIC_SELFTEST_OP, ext_memory_check_fail_i,
                                    11'h000};
                    end
                    `FIC_CMD_WIDE16, `FIC_CMD_WIDE8:
                    begin
                        rsp_valid = 1'b0;
                        do_wide   = link.cmd_wr;
                        do_srst   = link.cmd_wr;
                    end
                    `FIC_CMD_ID:  rsp_word = DEVICE_CODE;
                    `FIC_CMD_REV: rsp_word = REV_CODE;
                    default:
                    begin
                        if (link.cmd_word[15:12] == `FIC_TONE_OP && link.cmd_word[11:9] == 3'h0)
                        begin
                            // Tone needs idle; reply waits for the frame end
                            rsp_valid = 1'b0;
                            if (speech_active_i)
                            begin
                                rsp_valid = link.cmd_wr;
                                rsp_word  = `FIC_STS_REFUSED;
                            end
                            else
                                go_tone = link.cmd_wr;
                        end
                    end
                endcase
                if (!link.cmd_wr)
                begin
                    do_en   = 1'b0;
                    do_dis  = 1'b0;
                    do_clr  = 1'b0;
                    do_sram = 1'b0;
                    go_rate = 1'b0;
                end
            end
        endcase
    end

    // Mode state
    always_ff @(posedge clk_i)
    begin
        if (rst_all)
            state_q <= ST_IDLE;
        else if (go_rate)
            state_q <= ST_RATE_WAIT;
        else if (go_tone)
            state_q <= ST_TONE;
        else if (go_idle)
            state_q <= ST_IDLE;
    end

    // Command parked in tone mode until the next frame end
    always_ff @(posedge clk_i)
    begin
        if (rst_all || go_idle || go_tone)
        begin
            pend_q     <= go_tone ? link.cmd_word : 16'h0000;
            pend_vld_q <= go_tone;
        end
        else if (state_q == ST_TONE && link.cmd_wr)
        begin
            pend_q     <= link.cmd_word;
            pend_vld_q <= 1'b1;
        end
        else if (frame_tick)
            pend_vld_q <= 1'b0; // No new word: last tone keeps going
    end

    // Tone parameters; slot zero stays silent but keeps frame timing
    always_ff @(posedge clk_i)
    begin
        if (rst_all || go_idle)
        begin
            tone_on_o <= 1'b0;
            slot_q    <= 5'h00;
            att_q     <= 4'h0;
        end
        else if (tone_upd)
        begin
            slot_q    <= tw[`FIC_SLOT_MSB:0];
            att_q     <= tw[`FIC_ATT_MSB:`FIC_ATT_LSB];
            tone_on_o <= (tw[`FIC_SLOT_MSB:0] != 5'h00);
        end
    end

    // Output level saturates at the quietest step
    assign level_sum    = {1'b0, `FIC_TABLE_LEVEL} + {1'b0, att_q};
    assign tone_level_o = (level_sum > `FIC_LEVEL_MAX) ? 4'hf : level_sum[3:0];
    assign tone_slot_o  = slot_q;
    assign tone_codec_o = (codec_route_i == `FIC_ROUTE_DEFAULT) ? 2'h1 : codec_route_i;

    // Status reply; a new reply wins over the host read
    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            status_q     <= 16'h0000;
            status_rdy_q <= 1'b0;
        end
        else if (rsp_valid)
        begin
            status_q     <= rsp_word;
            status_rdy_q <= 1'b1;
        end
        else if (link.status_rd)
            status_rdy_q <= 1'b0;
    end

    // Strobe enable and the strobe itself; a frame wins over a clear
    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            strb_en_q <= 1'b1;
            strobe_q  <= 1'b0;
        end
        else
        begin
            if (do_en)
                strb_en_q <= 1'b1;
            else if (do_dis)
                strb_en_q <= 1'b0;
            if (frame_tick && speech_active_i && strb_en_q && !do_dis)
                strobe_q <= 1'b1;
            else if (do_clr || do_dis)
                strobe_q <= 1'b0;
        end
    end

    // Pin 5 carries the strobe only while it is enabled
    always_comb
    begin
        gpio_pin_o  = gpio_out_i;
        gpio_oe_n_o = gpio_oe_n_i;
        if (strb_en_q)
        begin
            gpio_pin_o[`FIC_STB_BIT]  = ~strobe_q;
            gpio_oe_n_o[`FIC_STB_BIT] = 1'b0;
        end
    end
    assign gpio_level_o = lvl_q;

    // Frame counter and periodic aux updates
    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            act_q  <= 1'b0;
            fc_q   <= 16'h0000;
            nth_q  <= 16'h0000;
            rate_q <= 16'h0000;
        end
        else
        begin
            act_q <= speech_active_i;
            if (state_q == ST_RATE_WAIT && link.cmd_wr)
            begin
                rate_q <= link.cmd_word;
                nth_q  <= 16'h0000;
            end
            if (speech_active_i && !act_q)
            begin
                fc_q  <= 16'h0000;
                nth_q <= 16'h0000;
            end
            else if (speech_active_i && frame_tick)
            begin
                fc_q  <= fc_q + 16'h0001;
                nth_q <= (nth_q + 16'h0001 >= rate_q) ? 16'h0000 : nth_q + 16'h0001;
            end
        end
    end

    // Aux word write; a write wins over the host read
    always_ff @(posedge clk_i)
    begin
        if (rst_all)
        begin
            aux_q     <= 16'h0000;
            aux_rdy_q <= 1'b0;
        end
        else if (speech_active_i && act_q && frame_tick && rate_q != 16'h0000
                 && nth_q + 16'h0001 >= rate_q)
        begin
            aux_q     <= fc_q + 16'h0001;
            aux_rdy_q <= 1'b1;
        end
        else if (link.aux_rd)
            aux_rdy_q <= 1'b0;
    end

    // Interrupt, width, memory test
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_n_q     <= 1'b1;
            srst_q      <= 1'b0;
            mem_wide_q  <= 1'b0;
            sram_test_q <= 1'b0;
        end
        else
        begin
            irq_n_q <= ~((link.irq_sel[0] && send_buffer_ok_i) ||
                         (link.irq_sel[1] && receive_buffer_ok_i) ||
                         (link.irq_sel[2] && aux_rdy_q));
            srst_q      <= do_srst;
            sram_test_q <= do_sram;
            if (do_wide)
                mem_wide_q <= (link.cmd_word == `FIC_CMD_WIDE16);
        end
    end

    assign link.status_word      = status_q;
    assign link.status_rdy       = status_rdy_q;
    assign link.aux_word         = aux_q;
    assign link.aux_rdy          = aux_rdy_q;
    assign link.host_interrupt_n = irq_n_q;
    assign mem_wide_o            = mem_wide_q;
    assign sram_test_o           = sram_test_q;
endmodule // fic_device

// ---- design/fic_host.sv ----
`timescale 1ns/1ps
`include "fic_regs.svh"
module fic_host
    import fic_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES = `FIC_WIDTH_WAIT_CYC
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    fic_if.host              link
);
    logic        ack_q, acc, busy_q, cmd_wr_q, st_rd_q, aux_rd_q;
    logic [15:0] cmd_q;
    logic [2:0]  sel_q;
    logic [23:0] hold_q;
    logic        hold_on, wide_cmd, cmd_ok;

    // Access completes on the edge where the master sees ack
    assign acc      = wb_cyc_i && wb_stb_i && ack_q;
    assign hold_on  = (hold_q != 24'h000000);
    assign wide_cmd = (wb_dat_i[15:0] == `FIC_CMD_WIDE16) || (wb_dat_i[15:0] == `FIC_CMD_WIDE8);
    // Refuse a new word until the last reply is read or the wait ends
    assign cmd_ok   = acc && wb_we_i && wb_adr_i[4:2] == `FIC_REG_CMD && wb_sel_i[1:0] == 2'h3
                      && !busy_q && !hold_on;

    // One wait state, ack dropped the cycle after it was given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end

    // Read data settles together with ack; unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h00000000;
        else if (wb_cyc_i && wb_stb_i && !ack_q)
        begin
            case (wb_adr_i[4:2])
                `FIC_REG_STATUS: wb_dat_o <= {16'h0000, link.status_word};
                `FIC_REG_CTRL:   wb_dat_o <= {29'h00000000, sel_q};
                `FIC_REG_FLAGS:  wb_dat_o <= {27'h0000000, link.aux_rdy, ~link.host_interrupt_n,
                                              hold_on, busy_q, link.status_rdy};
                `FIC_REG_AUX:    wb_dat_o <= {16'h0000, link.aux_word};
                default:         wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Command issue, busy tracking and read-clear pulses
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_q    <= 16'h0000;
            cmd_wr_q <= 1'b0;
            busy_q   <= 1'b0;
            st_rd_q  <= 1'b0;
            aux_rd_q <= 1'b0;
            sel_q    <= 3'h0;
        end
        else
        begin
            cmd_wr_q <= cmd_ok;
            st_rd_q  <= acc && !wb_we_i && wb_adr_i[4:2] == `FIC_REG_STATUS;
            aux_rd_q <= acc && !wb_we_i && wb_adr_i[4:2] == `FIC_REG_AUX;
            if (cmd_ok)
                cmd_q <= wb_dat_i[15:0];
            if (cmd_ok && !wide_cmd)
                busy_q <= 1'b1;
            else if (acc && !wb_we_i && wb_adr_i[4:2] == `FIC_REG_STATUS && link.status_rdy)
                busy_q <= 1'b0;
            if (acc && wb_we_i && wb_adr_i[4:2] == `FIC_REG_CTRL && wb_sel_i[0])
                sel_q <= wb_dat_i[2:0];
        end
    end

    // Quiet period after a memory width change
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            hold_q <= 24'h000000;
        else if (cmd_ok && wide_cmd)
            hold_q <= 24'(HOLDOFF_CYCLES);
        else if (hold_on)
            hold_q <= hold_q - 24'h000001;
    end

    assign wb_ack_o       = ack_q;
    assign link.cmd_word  = cmd_q;
    assign link.cmd_wr    = cmd_wr_q;
    assign link.status_rd = st_rd_q;
    assign link.aux_rd    = aux_rd_q;
    assign link.irq_sel   = sel_q;
endmodule // fic_host

// ---- testbench/fic_checker_sva.sv ----
`timescale 1ns/1ps
module fic_checker
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] cmd_word,
    input wire logic        cmd_wr,
    input wire logic [15:0] status_word,
    input wire logic        status_rdy,
    input wire logic        status_rd,
    input wire logic        aux_rdy,
    input wire logic [2:0]  irq_sel,
    input wire logic        host_interrupt_n
);
    // One clock domain, so clocking and reset are given once
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_strobe_echo:
        assert property (cmd_wr && (cmd_word == 16'h5141 || cmd_word == 16'h5142)
            |=> status_rdy && status_word == $past(cmd_word)) else $error("bad strobe echo");
    a_rom_nibble:
        assert property (cmd_wr && cmd_word == 16'h3000 |=> status_rdy
            && status_word[15:12] == 4'h3) else $error("bad rom reply");
    a_sram_nibble:
        assert property (cmd_wr && cmd_word == 16'h3001 |=> status_rdy
            && status_word[15:12] == 4'h3) else $error("bad sram reply");
    a_width_silent:
        assert property (cmd_wr && (cmd_word == 16'h0801 || cmd_word == 16'h0821)
            |=> !status_rdy [*3]) else $error("width command replied");
    // Ready must not vanish before the host has taken the reply
    a_ready_holds:
        assert property (status_rdy && !status_rd |=> status_rdy) else $error("ready lost");
    a_tone_reply:
        assert property (cmd_wr && cmd_word[15:12] == 4'h6 |-> ##[1:1000] status_rdy)
            else $error("no tone reply");
    a_irq_aux:
        assert property (irq_sel[2] && aux_rdy |=> !host_interrupt_n) else $error("aux irq");
    a_irq_off:
        assert property (irq_sel == 3'h0 |=> host_interrupt_n) else $error("stray irq");
endmodule // fic_checker

// ---- testbench/test_frame_irq_selftest_tone_cmds.sv ----
`timescale 1ns/1ps
module test_frame_irq_selftest_tone_cmds;
    import fic_pkg::*;
    logic         clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, spk = 0, sok = 0, df = 0;
    logic [4:0]   adr = 0, slot;
    logic [31:0]  wdat = 0, rdat, rd;
    logic [1:0]   route = 0, tcod;
    logic [2:0]   fail = 0;
    logic [7:0]   gin = 0, gout = 0, pin, oen, lvl;
    logic [3:0]   tlev;
    logic         wide, ton, stst, stk, seen = 0;
    fic_word_type w;
    int           bad_count = 0, checked = 0, k, att, sl, lev;
    fic_if link ();
    always #5 clk_i = ~clk_i;
    // The memory test pulse lasts one cycle, so it is latched as it passes
    always @(posedge clk_i) if (stst === 1'b1) seen <= 1;
    fic_device #(.SAMPLE_CYCLES(4)) u_fic_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .speech_active_i(spk), .send_buffer_ok_i(sok), .receive_buffer_ok_i(1'b0),
        .data_flag_i(df), .codec_route_i(route), .table_rom_check_fail_i(fail[0]),
        .code_rom_check_fail_i(fail[1]), .ext_memory_check_fail_i(fail[2]), .gpio_pin_i(gin),
        .gpio_out_i(gout), .gpio_oe_n_i(~gout), .gpio_pin_o(pin), .gpio_oe_n_o(oen),
        .gpio_level_o(lvl), .mem_wide_o(wide), .sram_test_o(stst), .tone_on_o(ton),
        .tone_slot_o(slot), .tone_level_o(tlev), .tone_codec_o(tcod), .sample_tick_o(stk));
    fic_host #(.HOLDOFF_CYCLES(8)) u_fic_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
    fic_checker u_fic_checker (.clk_i(clk_i), .rst_i(rst_i), .cmd_word(link.cmd_word),
        .cmd_wr(link.cmd_wr), .status_word(link.status_word), .status_rdy(link.status_rdy),
        .status_rd(link.status_rd), .aux_rdy(link.aux_rdy), .irq_sel(link.irq_sel),
        .host_interrupt_n(link.host_interrupt_n));
    task automatic chk(input string n, input logic [15:0] e, g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic stop;
        bad_count++;
        print_verdict();
    endtask
    // Classic cycle held until ack; read data taken at that same edge
    task automatic wb(input logic wr, input logic [4:0] ad, input logic [15:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1;
        we <= wr;
        adr <= ad;
        wdat <= {16'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
        rd = rdat;
        cyc <= 0;
        if (n >= 20) stop();
    endtask
    // Polls the flag register until bit b reads v
    task automatic poll(input int b, input logic v);
        int n = 0;
        do wb(0, 5'h0c, 0); while (rd[b] !== v && ++n < 500);
        if (n >= 500) stop();
    endtask
    // Command, wait for ready, read reply, compare under a mask
    task automatic cmd(input fic_word_type c, e, input string n, input fic_word_type m = '1);
        wb(1, 5'h00, c);
        poll(0, 1);
        wb(0, 5'h04, 0);
        chk(n, e & m, rd[15:0] & m);
    endtask
    initial begin
        void'($urandom(12));
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        {gin, gout, df, fail} <= 20'($urandom);
        repeat (8) @(posedge clk_i);
        cmd(16'h5143, {8'h0, gin[7:6], 2'b10, gin[3:1], df}, "rdstb");
        chk("sync", {8'h0, gin}, {8'h0, lvl});
        cmd(16'h3000, {4'h3, 1'b0, fail[0], fail[1], 9'h0}, "rom", 16'hf600);
        cmd(16'h3001, {4'h3, fail[2], 11'h0}, "sram", 16'hf800);
        chk("sram pulse", 1, seen);
        $display("self test done");
        cmd(16'h5145, 16'h5145, "rate");
        cmd(16'h0002, 16'h0002, "rate n");
        wb(1, 5'h08, 16'h0004);
        spk <= 1;
        for (k = 0; k < 3000 && link.host_interrupt_n !== 1'b0; k++) @(posedge clk_i);
        chk("aux irq", 0, link.host_interrupt_n);
        wb(0, 5'h10, 0);
        chk("aux", 2, rd[15:0]);
        cmd(16'h5144, 16'h0002, "count");
        chk("aux clr", 1, link.host_interrupt_n);
        chk("pin5 low", 0, pin[5]);
        cmd(16'h5140, 16'h0000, "clear", 16'h0020);
        chk("pin5", 1, pin[5]);
        cmd(16'h6021, 16'hffff, "refuse");
        wb(1, 5'h08, 16'h0001);
        sok <= 1;
        repeat (3) @(posedge clk_i);
        chk("buf irq", 0, link.host_interrupt_n);
        cmd(16'h5142, 16'h5142, "disable");
        chk("gpio5", {gout[5], ~gout[5]}, {pin[5], oen[5]});
        cmd(16'h5141, 16'h5141, "enable");
        spk <= 0;
        $display("frame test done");
        // Repeated tone words, slot zero first, last offset saturating
        for (k = 0; k < 4; k++)
        begin
            att = (k == 3) ? 15 : $urandom % 16;
            sl = (k == 0) ? 0 : $urandom % 32;
            route <= k[1:0];
            w = {4'h6, 3'h0, att[3:0], sl[4:0]};
            cmd(w, w, "tone");
            lev = (att + 1 > 15) ? 15 : att + 1;
            chk("level", lev[15:0], {12'h0, tlev});
            chk("slot", sl[15:0], {11'h0, slot});
            chk("tone on", sl != 0, ton);
            chk("codec", (k == 0) ? 1 : k, {14'h0, tcod});
        end
        cmd(16'h0000, 16'h0000, "idle");
        chk("tone off", 0, ton);
        $display("tone test done");
        // Sample enable spacing, measured from one pulse to the next
        for (k = 0; k < 9 && stk !== 1'b1; k++) @(posedge clk_i);
        @(posedge clk_i);
        for (k = 1; k < 9 && stk !== 1'b1; k++) @(posedge clk_i);
        chk("tick gap", 4, k);
        wb(1, 5'h00, 16'h0801);
        poll(2, 0);
        chk("wide", 1, wide);
        cmd(16'h0000, 16'h0000, "idle");
        $display("width test done");
        print_verdict();
    end
    // Guard against a hang anywhere in the sequence
    initial begin
        repeat (100000) @(posedge clk_i);
        stop();
    end
endmodule // test_frame_irq_selftest_tone_cmds
